// >>> wwd_regs.vh
// Constants for the windowed watchdog: register indices, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the watchdog design files.
`ifndef WWD_REGS_VH
`define WWD_REGS_VH

////////////////////////////////////////////////////////////////////////
// Register indices (byte address is four times the index)
`define WWD_IDX_CTRL 2'h0
`define WWD_IDX_STATUS 2'h1

////////////////////////////////////////////////////////////////////////
// Control register fields
`define WWD_CTRL_PER_LSB 0
`define WWD_CTRL_PER_MSB 3
`define WWD_CTRL_WIN_LSB 4
`define WWD_CTRL_WIN_MSB 7
`define WWD_CTRL_RESET 8'h00

////////////////////////////////////////////////////////////////////////
// Status register fields
`define WWD_STAT_LOCK_BIT 7
`define WWD_STAT_BUSY_BIT 0
`define WWD_STAT_RESET 8'h00

////////////////////////////////////////////////////////////////////////
// Length codes and timing
`define WWD_CODE_OFF 4'h0
`define WWD_CODE_MAX 4'hB
`define WWD_LEN_MIN 14'h0008
`define WWD_LEN_W 14
`define WWD_TICK_HZ 1024
`define WWD_SYNC_TICKS 2'h2

`endif

// >>> wwd_sync2.v
// Two-stage synchroniser for levels entering the pclk domain.
// Assumes the input may change at any time relative to pclk.
`timescale 1ns/1ns
module wwd_sync2 #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage feeds only the second
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule // wwd_sync2

// >>> wwd_len_decode.v
// Decodes a 4-bit length code into a count of watchdog ticks.
// Assumes codes 1..11 are legal; zero and the rest decode as invalid.
`timescale 1ns/1ns
`include "wwd_regs.vh"
module wwd_len_decode (
  input wire [3:0] code,
  output wire valid,
  output wire [13:0] len
);

  wire [3:0] shift;

  // Doubling count per code step, from 8 ticks up
  assign valid = (code != `WWD_CODE_OFF) && (code <= `WWD_CODE_MAX);
  assign shift = code - 4'h1;
  assign len = valid ? (`WWD_LEN_MIN << shift) : 14'h0000;

endmodule // wwd_len_decode

// >>> wwd_top.v
// Windowed watchdog timer with an APB register slave.
// Assumes the tick input is a free-running slow square wave from an
// independent oscillator; core-side strobes are synchronous to pclk.
//
// Function
// - Period field 1..11 enables the watchdog; zero or 12..15 keeps it off.
// - Window field 1..11 enters window mode; zero or 12..15 leaves it.
// - Normal mode holds while the window field is zero.
// - Control resets from fuse; fuse period 1..11 enables, any non-zero one locks.
// - Counting uses the slow 1.024 kHz tick, asynchronous to pclk.
// - Normal mode: no clear before timeout gives a system reset.
// - Every clear restarts the timeout from zero.
// - Eleven timeout periods, 8 ms to 8 s, set by period field.
// - Window mode: clear during closed period gives a system reset.
// - Open period follows closed; clear needed within the open period.
// - Window sequence starts only after the first clear.
// - Lock blocks control writes; software may set lock, and clear it only in debug.
// - Counting continues in sleep while the tick source runs.
// - Debug halt stops operation and zeroes the counter.
// - Leaving debug in window mode runs a normal period first.
// - Control writes cross to tick domain; busy flag shows it.
// - A clear takes one to two tick periods before the restart.
// - Protected writes without a valid unlock are ignored.
// - Codes 1..11 give 8..8192 ticks; window mode period is open length.
// - Busy sets on control write, clears when value reaches tick domain.
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`include "wwd_regs.vh"
module wwd_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [3:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire wdt_tick_in,
  input wire software_clear_instr,
  input wire change_protection_ok,
  input wire debug_halt,
  input wire debug_mode,
  input wire [7:0] fuse_watchdog_config,
  output wire sys_reset,
  output wire wdt_running
);

  ////////////////////////////////////////////////////////////////////////
  // State encoding, one-hot
  localparam [3:0] ST_OFF = 4'h1;
  localparam [3:0] ST_NORM = 4'h2;
  localparam [3:0] ST_CLOSED = 4'h4;
  localparam [3:0] ST_OPEN = 4'h8;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  wire tick_sync;
  wire tick_en;
  wire setup_ph;
  wire access_ph;
  wire hit_ctrl;
  wire hit_status;
  wire addr_ok;
  wire wr_ctrl;
  wire wr_status;
  wire per_ok;
  wire win_ok;
  wire [13:0] per_len;
  wire [13:0] win_len;
  wire ctrl_apply;
  wire clr_apply;
  wire [7:0] status_val;

  reg tick_last_q;
  reg boot_q;
  reg [7:0] ctrl_q;
  reg [7:0] act_ctrl_q;
  reg lock_q;
  reg busy_q;
  reg [1:0] busy_cnt_q;
  reg clr_pend_q;
  reg [1:0] clr_cnt_q;
  reg [3:0] st_q;
  reg [3:0] st_d;
  reg [13:0] cnt_q;
  reg [13:0] cnt_d;
  reg rst_q;
  reg rst_d;
  reg [31:0] prdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Tick crossing: two flops, then a rising-edge enable
  wwd_sync2 #(
    .W(1)
  ) u_tick_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din(wdt_tick_in),
    .dout(tick_sync)
  );

  // Edge detector on the synchronised level
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_last_q <= 1'b0;
    else
      tick_last_q <= tick_sync;
  end

  // One pulse per slow tick, independent of sleep state
  assign tick_en = tick_sync & ~tick_last_q;

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_ctrl = (paddr[3:2] == `WWD_IDX_CTRL) && (paddr[1:0] == 2'h0);
  assign hit_status = (paddr[3:2] == `WWD_IDX_STATUS) && (paddr[1:0] == 2'h0);
  assign addr_ok = hit_ctrl | hit_status;
  assign wr_ctrl = access_ph & pwrite & hit_ctrl;
  assign wr_status = access_ph & pwrite & hit_status;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_ph & ~addr_ok;

  ////////////////////////////////////////////////////////////////////////
  // Length decode of the active settings
  wwd_len_decode u_per_dec (
    .code(act_ctrl_q[`WWD_CTRL_PER_MSB:`WWD_CTRL_PER_LSB]),
    .valid(per_ok),
    .len(per_len)
  );

  wwd_len_decode u_win_dec (
    .code(act_ctrl_q[`WWD_CTRL_WIN_MSB:`WWD_CTRL_WIN_LSB]),
    .valid(win_ok),
    .len(win_len)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control shadow, lock and fuse preset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_q <= 1'b0;
      ctrl_q <= `WWD_CTRL_RESET;
      lock_q <= 1'b0;
    end
    else if (!boot_q)
    begin
      // Fuse caught on the first edge after release
      boot_q <= 1'b1;
      ctrl_q <= fuse_watchdog_config;
      lock_q <= (fuse_watchdog_config[`WWD_CTRL_PER_MSB:`WWD_CTRL_PER_LSB]
                 != `WWD_CODE_OFF);
    end
    else
    begin
      // Protected, lock-gated control write
      if (wr_ctrl && change_protection_ok && !lock_q)
        ctrl_q <= pwdata[7:0];
      // Lock may be set by software, cleared only in debug
      if (wr_status && change_protection_ok)
      begin
        if (pwdata[`WWD_STAT_LOCK_BIT])
          lock_q <= 1'b1;
        else if (debug_mode)
          lock_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control crossing into the tick domain
  assign ctrl_apply = busy_q & tick_en & (busy_cnt_q == (`WWD_SYNC_TICKS - 2'h1));

  // Busy flag and active copy of the control fields
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_q <= 1'b0;
      busy_cnt_q <= 2'h0;
      act_ctrl_q <= `WWD_CTRL_RESET;
    end
    else if (!boot_q)
    begin
      // Fuse value is live at boot, no crossing needed
      act_ctrl_q <= fuse_watchdog_config;
    end
    else if (wr_ctrl && change_protection_ok && !lock_q)
    begin
      // A new write restarts the crossing
      busy_q <= 1'b1;
      busy_cnt_q <= 2'h0;
    end
    else if (ctrl_apply)
    begin
      busy_q <= 1'b0;
      busy_cnt_q <= 2'h0;
      act_ctrl_q <= ctrl_q;
    end
    else if (busy_q && tick_en)
    begin
      busy_cnt_q <= busy_cnt_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clear instruction crossing
  assign clr_apply = clr_pend_q & tick_en & (clr_cnt_q == (`WWD_SYNC_TICKS - 2'h1));

  // Pending clear; a new instruction wins over the apply
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clr_pend_q <= 1'b0;
      clr_cnt_q <= 2'h0;
    end
    else if (debug_halt)
    begin
      // Halted core cannot clear; drop anything in flight
      clr_pend_q <= 1'b0;
      clr_cnt_q <= 2'h0;
    end
    else if (software_clear_instr)
    begin
      clr_pend_q <= 1'b1;
      clr_cnt_q <= 2'h0;
    end
    else if (clr_apply)
    begin
      clr_pend_q <= 1'b0;
      clr_cnt_q <= 2'h0;
    end
    else if (clr_pend_q && tick_en)
    begin
      clr_cnt_q <= clr_cnt_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog state machine, advanced on tick enables
  always @*
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    rst_d = 1'b0;
    if (!per_ok)
    begin
      // Period off or reserved: watchdog idle
      st_d = ST_OFF;
      cnt_d = 14'h0000;
    end
    else if (debug_halt)
    begin
      // Frozen and zeroed; resumes with a plain period
      st_d = ST_NORM;
      cnt_d = 14'h0000;
    end
    else
    begin
      case (st_q)
        ST_OFF:
        begin
          st_d = ST_NORM;
          cnt_d = 14'h0000;
        end
        ST_NORM:
        begin
          if (clr_apply)
          begin
            cnt_d = 14'h0000;
            if (win_ok)
              st_d = ST_CLOSED;
          end
          else if (tick_en)
          begin
            if (cnt_q == (per_len - 14'h0001))
            begin
              rst_d = 1'b1;
              cnt_d = 14'h0000;
            end
            else
              cnt_d = cnt_q + 14'h0001;
          end
        end
        ST_CLOSED:
        begin
          if (!win_ok)
          begin
            st_d = ST_NORM;
            cnt_d = 14'h0000;
          end
          else if (clr_apply)
          begin
            // Too early
            rst_d = 1'b1;
            st_d = ST_NORM;
            cnt_d = 14'h0000;
          end
          else if (tick_en)
          begin
            if (cnt_q == (win_len - 14'h0001))
            begin
              st_d = ST_OPEN;
              cnt_d = 14'h0000;
            end
            else
              cnt_d = cnt_q + 14'h0001;
          end
        end
        ST_OPEN:
        begin
          if (!win_ok)
          begin
            st_d = ST_NORM;
            cnt_d = 14'h0000;
          end
          else if (clr_apply)
          begin
            st_d = ST_CLOSED;
            cnt_d = 14'h0000;
          end
          else if (tick_en)
          begin
            if (cnt_q == (per_len - 14'h0001))
            begin
              // Too late
              rst_d = 1'b1;
              st_d = ST_NORM;
              cnt_d = 14'h0000;
            end
            else
              cnt_d = cnt_q + 14'h0001;
          end
        end
        default:
        begin
          st_d = ST_OFF;
          cnt_d = 14'h0000;
        end
      endcase
    end
  end

  // State, counter and registered reset pulse
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_OFF;
      cnt_q <= 14'h0000;
      rst_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rst_q <= rst_d;
    end
  end

  assign sys_reset = rst_q;
  assign wdt_running = ~st_q[0];

  ////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase
  assign status_val = {lock_q, 6'h00, busy_q};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h00000000;
    else if (setup_ph && !pwrite)
    begin
      if (hit_ctrl)
        prdata_q <= {24'h000000, ctrl_q};
      else if (hit_status)
        prdata_q <= {24'h000000, status_val};
      else
        prdata_q <= 32'h00000000;
    end
  end

  assign prdata = prdata_q;

endmodule // wwd_top

// >>> wwd_checker_assertions.sv
// Port checker for the windowed watchdog top level.
// Assumes every watched port except wdt_tick_in belongs to the pclk domain.
`timescale 1ns/1ns
module wwd_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [3:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire wdt_tick_in,
  input wire software_clear_instr,
  input wire debug_halt,
  input wire [7:0] fuse_watchdog_config,
  input wire sys_reset,
  input wire wdt_running
);
  logic [2:0] tk_q;
  logic [3:0] cnt_q;
  logic seen_q;
  wire fuse_on = fuse_watchdog_config[3:0] != 4'h0 && fuse_watchdog_config[3:0] < 4'hC;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_halted;
    debug_halt [*3];
  endsequence
  sequence s_off;
    !wdt_running [*3];
  endsequence
  // Ticks since last pulse; flag any clear or write
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tk_q <= 3'h0;
      cnt_q <= 4'h0;
      seen_q <= 1'h0;
    end
    else
    begin
      tk_q <= {tk_q[1:0], wdt_tick_in};
      if (sys_reset)
      begin
        cnt_q <= 4'h0;
        seen_q <= 1'h0;
      end
      else
      begin
        if (tk_q[2:1] == 2'h1 && cnt_q != 4'hF)
          cnt_q <= cnt_q + 4'h1;
        if (software_clear_instr || (psel && penable && pwrite))
          seen_q <= 1'h1;
      end
    end
  end
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_err_map: assert property (psel && penable |-> pslverr == (paddr != 4'h0 && paddr != 4'h4))
    else $error("pslverr wrong for address");
  a_pulse_one: assert property (sys_reset |=> !sys_reset)
    else $error("system reset longer than one cycle");
  a_pulse_on: assert property (sys_reset |-> wdt_running)
    else $error("system reset while watchdog off");
  a_halt_quiet: assert property (s_halted |-> !sys_reset)
    else $error("system reset during debug halt");
  a_off_quiet: assert property (s_off |-> !sys_reset)
    else $error("system reset while disabled");
  a_no_early: assert property (sys_reset && !seen_q |-> cnt_q >= 4'h7)
    else $error("timeout shorter than eight ticks");
  a_fuse_load: assert property ($rose(presetn) |-> ##3 wdt_running == fuse_on)
    else $error("fuse setting not applied");
endmodule // wwd_checker
bind wwd_top wwd_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .wdt_tick_in(wdt_tick_in), .software_clear_instr(software_clear_instr),
  .debug_halt(debug_halt), .fuse_watchdog_config(fuse_watchdog_config),
  .sys_reset(sys_reset), .wdt_running(wdt_running));

// >>> wwd_core_model.sv
// Behavioural core: clear pulses and key unlock window.
// Assumes bench requests are synchronous to pclk.
`timescale 1ns/1ns
module wwd_core_model (
  input wire pclk,
  input wire presetn,
  input wire clr_req,
  input wire unlock_req,
  output logic software_clear_instr,
  output wire change_protection_ok
);
  logic [2:0] win_q;
  // One-cycle clear; unlock lasts four cycles
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      software_clear_instr <= 1'h0;
      win_q <= 3'h0;
    end
    else
    begin
      software_clear_instr <= clr_req;
      win_q <= unlock_req ? 3'h4 : win_q - {2'h0, win_q != 3'h0};
    end
  end
  assign change_protection_ok = win_q != 3'h0;
endmodule // wwd_core_model

// >>> windowed_watchdog_timer_test.sv
// Self-checking bench for the windowed watchdog top level.
// Assumes a fast stand-in tick so every timeout fits a short run.
`timescale 1ns/1ns
module windowed_watchdog_timer_test;
  typedef struct {logic w; logic [3:0] a; logic [7:0] d; logic u; logic [7:0] e; logic r;} wwd_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tick = 0;
  logic creq = 0, unl = 0, halt = 0, dbg = 0, err;
  logic [3:0] paddr = 4'h0;
  logic [7:0] fuse = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, swc, cpok, sys_reset, run;
  int fail_count = 0, samples_checked = 0, n, i;
  wwd_row_t rows [9] = '{'{1'h0, 4'h0, 8'h00, 1'h0, 8'h00, 1'h0},
    '{1'h0, 4'h4, 8'h00, 1'h0, 8'h00, 1'h0}, '{1'h1, 4'h0, 8'h01, 1'h0, 8'h00, 1'h0},
    '{1'h0, 4'h0, 8'h00, 1'h0, 8'h00, 1'h0}, '{1'h1, 4'h0, 8'h01, 1'h1, 8'h00, 1'h0},
    '{1'h0, 4'h4, 8'h00, 1'h0, 8'h01, 1'h0}, '{1'h0, 4'h0, 8'h00, 1'h0, 8'h01, 1'h0},
    '{1'h0, 4'h8, 8'h00, 1'h0, 8'h00, 1'h1}, '{1'h1, 4'hC, 8'hFF, 1'h1, 8'h00, 1'h1}};
  wwd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdt_tick_in(tick), .software_clear_instr(swc),
    .change_protection_ok(cpok), .debug_halt(halt), .debug_mode(dbg),
    .fuse_watchdog_config(fuse), .sys_reset(sys_reset), .wdt_running(run));
  wwd_core_model u_core (.pclk(pclk), .presetn(presetn), .clr_req(creq), .unlock_req(unl),
    .software_clear_instr(swc), .change_protection_ok(cpok));
  // Clocks; the fast stand-in tick toggles on falling pclk edges only
  initial forever #2 pclk = ~pclk;
  initial forever #24 tick = ~tick;
  ////////////////////////////////////////
  task final_report;
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, optionally after a key unlock
  task apb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic u);
    int k;
    k = 0;
    @(posedge pclk) unl <= u;
    @(posedge pclk);
    unl <= 1'h0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && k < 50)
    begin
      k++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k == 50)
    begin
      chk(32'h0, 32'h1);
      final_report;
    end
  endtask
  // Poll status until the crossing is done
  task idle;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'h0 && n < 20)
    begin
      apb(1'h0, 4'h4, 32'h0, 1'h0);
      n++;
    end
    chk(rd & 32'h1, 32'h0);
    if (n == 20)
      final_report;
  endtask
  task clr;
    @(posedge pclk) creq <= 1'h1;
    @(posedge pclk) creq <= 1'h0;
  endtask
  // Cycles until a system reset pulse, bounded
  task wait_rst(input int lim, input logic must);
    n = 0;
    @(posedge pclk);
    while (sys_reset !== 1'h1 && n < lim)
    begin
      n++;
      @(posedge pclk);
    end
    if (must && n == lim)
    begin
      chk(32'h0, 32'h1);
      final_report;
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    for (i = 0; i < 9; i++)
    begin
      apb(rows[i].w, rows[i].a, {24'h0, rows[i].d}, rows[i].u);
      chk({31'h0, err}, {31'h0, rows[i].r});
      if (!rows[i].w)
        chk(rd, {24'h0, rows[i].e});
    end
    idle;
    // Unserviced timeout repeats every eight ticks
    wait_rst(400, 1'h1);
    wait_rst(400, 1'h1);
    chk({31'h0, n >= 80 && n <= 104}, 32'h1);
    chk({31'h0, run}, 32'h1);
    for (i = 0; i < 10; i++)
    begin
      clr;
      wait_rst(44, 1'h0);
      chk(n, 44);
    end
    wait_rst(200, 1'h1);
    chk({31'h0, n + 45 >= 100 && n + 45 <= 145}, 32'h1);
    // Window mode: second clear lands in the closed period
    apb(1'h1, 4'h0, 32'h11, 1'h1);
    idle;
    clr;
    repeat (58) @(posedge pclk);
    clr;
    wait_rst(48, 1'h1);
    // Open-period clear is accepted; without one, closed plus open runs out
    clr;
    repeat (120) @(posedge pclk);
    clr;
    wait_rst(44, 1'h0);
    chk(n, 44);
    wait_rst(300, 1'h1);
    chk({31'h0, n >= 140 && n <= 190}, 32'h1);
    // Lock blocks control writes, clears only in debug
    apb(1'h1, 4'h4, 32'h80, 1'h1);
    apb(1'h1, 4'h0, 32'h00, 1'h1);
    apb(1'h0, 4'h0, 32'h0, 1'h0);
    chk(rd, 32'h11);
    apb(1'h1, 4'h4, 32'h00, 1'h1);
    apb(1'h0, 4'h4, 32'h0, 1'h0);
    chk(rd & 32'h80, 32'h80);
    @(posedge pclk) halt <= 1'h1;
    repeat (2) @(posedge pclk);
    wait_rst(300, 1'h0);
    chk(n, 300);
    @(posedge pclk) halt <= 1'h0;
    // After a halt the window waits for a first clear
    clr;
    wait_rst(44, 1'h0);
    chk(n, 44);
    dbg <= 1'h1;
    apb(1'h1, 4'h4, 32'h00, 1'h1);
    apb(1'h1, 4'h0, 32'h00, 1'h1);
    idle;
    repeat (4) @(posedge pclk);
    chk({31'h0, run}, 32'h0);
    // Mid-run reset with a non-zero fuse: enabled and locked at boot
    @(posedge pclk) presetn <= 1'h0;
    fuse <= 8'h01;
    dbg <= 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    apb(1'h0, 4'h0, 32'h0, 1'h0);
    chk(rd, 32'h01);
    apb(1'h0, 4'h4, 32'h0, 1'h0);
    chk(rd, 32'h80);
    chk({31'h0, run}, 32'h1);
    wait_rst(200, 1'h1);
    final_report;
  end
endmodule // windowed_watchdog_timer_test
